// ---- idle_mode_wake_sequencer_tb.sv ----
`timescale 1ns/10ps
module idle_mode_wake_sequencer_tb;
  import iws_pkg::*;
  // ----
  // Stimulus and observation
  // ----
  logic       clock = 1'b0, rst_b = 1'b0, fwSleep = 1'b0, fwWdtClear = 1'b0, fwIdle = 1'b0;
  logic       fwSecEn = 1'b1, fwGie = 1'b0, wdtTo = 1'b0, secStarted = 1'b1;
  logic       lossIn = 1'b0, internal_source_select = 1'b0, wdtEn = 1'b1, fs = 1'b0, ts = 1'b0, priEn;
  logic [1:0] fwCss = 2'h0;
  logic [2:0] fwFreq = 3'h0;
  logic [7:0] irqIn = 8'h0, irqEn = 8'h0, irqClr = 8'h0;
  logic       secRun, slowRc, fastEn, wdtClr, cpuRunning, vectorTaken, wdtResetSeen, v;
  logic [1:0] actSrc;
  int         seed, mismatches = 0, samples_checked = 0;
  logic [2:0] modes [5] = '{3'h4, 3'h0, 3'h5, 3'h6, 3'h7};

  always #12.5 clock = ~clock;
  iws_if link ();
  // Small counts keep the start-up and wake waits short
  iws_device #(.CPU_READY_DELAY_CYC(4), .TIOBST_CYC(4), .OST_CYC(8)) i_iws_device (.clock(clock), .rst_b(rst_b),
    .link(link), .wdtTimeout(wdtTo), .secOscStarted(secStarted), .clockLoss(lossIn), .primaryOscEnable(priEn),
    .secondaryOscRun(secRun), .slowInternalRcRun(slowRc), .fastInternalOscEnable(fastEn),
    .activeClockSource(actSrc), .wdtCounterClear(wdtClr));
  iws_firmware i_iws_firmware (.clock(clock), .rst_b(rst_b), .link(link), .fwSleep(fwSleep),
    .fwWdtClear(fwWdtClear), .fwIdleSelect(fwIdle), .fwClockSourceSelect(fwCss), .fwSecOscEnable(fwSecEn),
    .fwFreqSelect(fwFreq), .fwIntSource(internal_source_select), .fwGlobalIntEnable(fwGie), .fwWdtEnable(wdtEn),
    .fwFailSafeEnable(fs), .fwTwoSpeedEnable(ts), .irqIn(irqIn), .irqEnable(irqEn), .irqClear(irqClr),
    .cpuRunning(cpuRunning), .vectorTaken(vectorTaken), .wdtResetSeen(wdtResetSeen));
  iws_assertions #(.CPU_READY_DELAY_CYC(4)) i_iws_assertions (.clock(clock), .rst_b(rst_b), .sleepExec(link.sleepExec),
    .idleSelect(link.idleSelect), .clockSourceSelect(link.clockSourceSelect), .secOscEnable(link.secOscEnable),
    .internalFreqSelect(link.internalFreqSelect), .internalSourceSelect(link.internalSourceSelect),
    .globalIntEnable(link.globalIntEnable), .intFlags(link.intFlags), .intEnables(link.intEnables),
    .cpuClkEn(link.cpuClkEn), .periphClkEn(link.periphClkEn), .primaryClockReadyFlag(link.primaryClockReadyFlag),
    .secondaryOscRunningFlag(link.secondaryOscRunningFlag), .internalOscStableFlag(link.internalOscStableFlag),
    .intVectorBranch(link.intVectorBranch), .wdtResetPulse(link.wdtResetPulse));

  // ----
  // Helpers
  // ----
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc

  // Bounded wait for the core clock; vector pulse is caught on the way
  task automatic waitRun();
    v = 1'b0;
    for (int k = 0; k < 300 && cpuRunning !== 1'b1; k++)
    begin
      cyc(1);
      v = v | vectorTaken;
    end
    check({7'h0, cpuRunning}, 8'h1);
  endtask : waitRun

  task automatic sleepPulse(input logic idle, input logic [1:0] css);
    fwIdle = idle;
    fwCss = css;
    cyc(3);
    fwSleep = 1'b1;
    cyc(1);
    fwSleep = 1'b0;
  endtask : sleepPulse

  // Catches a one-cycle watchdog clear pulse within a short span
  task automatic seeClr();
    v = 1'b0;
    repeat (4)
    begin
      cyc(1);
      v = v | wdtClr;
    end
    check({7'h0, v}, 8'h1);
  endtask : seeClr

  function automatic logic [1:0] expSrc(input logic [1:0] css);
    return css[1] ? 2'h2 : css;
  endfunction : expSrc

  task automatic sleepWake(input logic idle, input logic [1:0] css);
    int b;
    b = $unsigned($random(seed)) % 8;
    fwGie = 1'($random(seed));
    irqEn = 8'h1 << b;
    sleepPulse(idle, css);
    cyc(12);
    check({1'b0, priEn, cpuRunning, link.periphClkEn, link.primaryClockReadyFlag, link.secondaryOscRunningFlag,
      link.internalOscStableFlag, slowRc}, {1'b0, idle && css == 2'h0, 1'b0, idle, idle && css == 2'h0,
      idle && css == 2'h1, idle && fwFreq != 3'h0, 1'b1});
    irqIn = irqEn;
    cyc(1);
    irqIn = 8'h0;
    waitRun();
    check({5'h0, v, actSrc}, {5'h0, fwGie, expSrc(css)});
    check({6'h0, link.primaryClockReadyFlag, secRun}, {6'h0, css == 2'h0, 1'b1});
    irqClr = irqEn;
    cyc(1);
    irqClr = 8'h0;
    cyc(2);
  endtask : sleepWake

  task automatic conclude();
    if (mismatches == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // ----
  // Scenarios
  // ----
  initial
  begin
    seed = 43781;
    cyc(4);
    rst_b = 1'b1;
    waitRun();
    check({6'h0, link.primaryClockReadyFlag, actSrc == 2'h0}, 8'h3);
    for (int i = 0; i < 5; i++)
      sleepWake(modes[i][2], modes[i][1:0]);
    fwFreq = 3'($unsigned($random(seed)) % 7 + 1);
    cyc(12);
    check({6'h0, fastEn, link.internalOscStableFlag}, 8'h3);
    sleepWake(1'b1, 2'h2);
    fwFreq = fwFreq ^ 3'h4;
    seeClr();
    fwWdtClear = 1'b1;
    cyc(1);
    fwWdtClear = 1'b0;
    seeClr();
    fwFreq = 3'h0;
    cyc(6);
    check({7'h0, link.internalOscStableFlag}, 8'h0);
    // Source select alone enables the fast output; a lost clock with the monitor on clears the watchdog
    internal_source_select = 1'b1;
    fs = 1'b1;
    lossIn = 1'b1;
    seeClr();
    lossIn = 1'b0;
    fs = 1'b0;
    cyc(8);
    check({6'h0, fastEn, link.internalOscStableFlag}, 8'h3);
    internal_source_select = 1'b0;
    fwSecEn = 1'b0;
    sleepPulse(1'b1, 2'h1);
    cyc(4);
    check({7'h0, cpuRunning}, 8'h1);
    fwSecEn = 1'b1;
    secStarted = 1'b0;
    sleepPulse(1'b1, 2'h1);
    cyc(6);
    check({6'h0, cpuRunning, link.periphClkEn}, 8'h0);
    secStarted = 1'b1;
    cyc(4);
    check({7'h0, link.periphClkEn}, 8'h1);
    wdtTo = 1'b1;
    cyc(1);
    wdtTo = 1'b0;
    waitRun();
    check({6'h0, actSrc}, 8'h1);
    cyc(3);
    wdtTo = 1'b1;
    cyc(1);
    wdtTo = 1'b0;
    v = 1'b0;
    repeat (3)
    begin
      cyc(1);
      v = v | wdtResetSeen;
    end
    check({6'h0, v, cpuRunning}, 8'h3);
    // Mid-run reset with two-speed start: early run on internal, then primary
    rst_b = 1'b0;
    ts = 1'b1;
    cyc(2);
    rst_b = 1'b1;
    waitRun();
    check({5'h0, link.primaryClockReadyFlag, actSrc}, 8'h2);
    fwCss = 2'h0;
    cyc(12);
    check({5'h0, link.primaryClockReadyFlag, actSrc}, 8'h4);
    conclude();
  end

  // Cuts a hang short well past the expected run length
  initial
  begin
    repeat (20000) @(posedge clock);
    mismatches++;
    conclude();
  end
endmodule : idle_mode_wake_sequencer_tb

// ---- iws_assertions.sv ----
`timescale 1ns/10ps
`include "iws_consts.svh"
module iws_assertions #(
  parameter int CPU_READY_DELAY_CYC = `IWS_CPU_READY_DELAY_CYC
) (
  input logic                   clock,
  input logic                   rst_b,
  input logic                   sleepExec,
  input logic                   idleSelect,
  input logic [1:0]             clockSourceSelect,
  input logic                   secOscEnable,
  input logic [`IWS_FREQ_W-1:0] internalFreqSelect,
  input logic                   internalSourceSelect,
  input logic                   globalIntEnable,
  input logic [7:0]             intFlags,
  input logic [7:0]             intEnables,
  input logic                   cpuClkEn,
  input logic                   periphClkEn,
  input logic                   primaryClockReadyFlag,
  input logic                   secondaryOscRunningFlag,
  input logic                   internalOscStableFlag,
  input logic                   intVectorBranch,
  input logic                   wdtResetPulse
);
  // ----
  // Sleep entry
  // ----
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic sleepTaken;
  // A sleep only counts while the core is clocked, so requests in idle are ignored
  assign sleepTaken = sleepExec && cpuClkEn;

  property p_idle_primary;
    sleepTaken && idleSelect && clockSourceSelect == 2'h0 |=> !cpuClkEn && periphClkEn
      && $stable(primaryClockReadyFlag) && $stable(internalOscStableFlag);
  endproperty
  a_idle_primary: assert property (p_idle_primary)
    else $error("primary idle entry wrong");
  property p_full_sleep;
    sleepTaken && !idleSelect && (clockSourceSelect != 2'h1 || secOscEnable) |=> !cpuClkEn && !periphClkEn
      && !primaryClockReadyFlag && !secondaryOscRunningFlag && !internalOscStableFlag;
  endproperty
  a_full_sleep: assert property (p_full_sleep)
    else $error("full sleep entry wrong");
  property p_refuse;
    sleepTaken && idleSelect && clockSourceSelect == 2'h1 && !secOscEnable |=> cpuClkEn [*2];
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("refused sleep stopped core");
  property p_idle_sec;
    sleepTaken && idleSelect && clockSourceSelect == 2'h1 && secOscEnable
      |=> !cpuClkEn && secondaryOscRunningFlag && !primaryClockReadyFlag;
  endproperty
  a_idle_sec: assert property (p_idle_sec)
    else $error("secondary idle entry wrong");
  property p_idle_int;
    sleepTaken && idleSelect && clockSourceSelect[1] |=> !cpuClkEn && !primaryClockReadyFlag;
  endproperty
  a_idle_int: assert property (p_idle_int)
    else $error("internal idle entry wrong");
  // ----
  // Wake, watchdog and internal oscillator off
  // ----
  property p_wake_delay;
    $rose(|(intFlags & intEnables)) && !cpuClkEn && periphClkEn |-> ##CPU_READY_DELAY_CYC !cpuClkEn ##1 cpuClkEn;
  endproperty
  a_wake_delay: assert property (p_wake_delay)
    else $error("wake delay wrong");
  property p_vector;
    intVectorBranch |-> $rose(cpuClkEn) && globalIntEnable ##1 !intVectorBranch;
  endproperty
  a_vector: assert property (p_vector)
    else $error("vector branch wrong");
  property p_wdt_run;
    wdtResetPulse |-> $past(cpuClkEn) && cpuClkEn ##1 !wdtResetPulse;
  endproperty
  a_wdt_run: assert property (p_wdt_run)
    else $error("watchdog reset outside run");
  property p_int_off;
    (internalFreqSelect == 3'h0 && !internalSourceSelect) [*4] |-> !internalOscStableFlag;
  endproperty
  a_int_off: assert property (p_int_off)
    else $error("stable flag set while off");
  c_idle: cover property (sleepTaken && idleSelect);
  c_vec: cover property (intVectorBranch);
  c_refuse: cover property (sleepTaken && idleSelect && clockSourceSelect == 2'h1 && !secOscEnable);
endmodule : iws_assertions

// ---- iws_consts.svh ----
// Overview of operation
// - Idle sleep gates CPU, peripherals keep clocking
// - Idle keeps slow RC and secondary oscillator
// - Only interrupt, watchdog or reset ends idle
// - Wake holds CPU for ready delay, same source
// - Wake leaves idle and source selects untouched
// - Watchdog in idle/sleep wakes to selected run
// - Select 00 idles on primary, ready stays set
// - Primary idle wake resumes on primary clock
// - Select 01 idles on secondary, primary stops
// - Secondary disabled makes idle sleep ignored
// - Peripheral clocks wait for secondary start
// - Secondary idle wake resumes on secondary
// - High select bit idles on internal oscillator
// - Fast internal enabled, stable flag after settle
// - Stable flag kept, or stays clear when off
// - Internal idle wake resumes on internal clock
// - Only enabled interrupt flags start the wake
// - Interrupt wake branches only when globally enabled
// - Watchdog while running gives watchdog reset
// - Watchdog cleared by sleep, clear, loss, retune
// - Reset held by startup timer, then ready
// - Two-speed start runs internal until primary ready and selected
// - Sleep without idle stops clocks, clears flags
`ifndef IWS_CONSTS_SVH
`define IWS_CONSTS_SVH

// ------------------------------------------------------------
// Clock and timing
// ------------------------------------------------------------
`define IWS_CLK_NS       25
`define IWS_CPU_READY_DELAY_NS      2000
`define IWS_TIOBST_NS    1000
`define IWS_OST_TOSC     1024
`define IWS_CPU_READY_DELAY_CYC     ((`IWS_CPU_READY_DELAY_NS + `IWS_CLK_NS - 1) / `IWS_CLK_NS)
`define IWS_TIOBST_CYC   ((`IWS_TIOBST_NS + `IWS_CLK_NS - 1) / `IWS_CLK_NS)
`define IWS_OST_CYC      (`IWS_OST_TOSC)
`define IWS_CNT_W        12

// ------------------------------------------------------------
// Clock source select encodings and sizes
// ------------------------------------------------------------
`define IWS_CSS_PRIMARY   2'h0
`define IWS_CSS_SECONDARY 2'h1
`define IWS_CSS_HIGH_BIT  1
`define IWS_FREQ_W        3
`define IWS_NUM_IRQ       8

`endif

// ---- iws_device.sv ----
`timescale 1ns/10ps
module iws_device #(
  parameter int CPU_READY_DELAY_CYC   = `IWS_CPU_READY_DELAY_CYC,
  parameter int TIOBST_CYC = `IWS_TIOBST_CYC,
  parameter int OST_CYC    = `IWS_OST_CYC,
  parameter bit PRIMARY_IS_INTERNAL = 1'b0
) (
  input  wire logic        clock,
  input  wire logic        rst_b,
  iws_if.dev               link,
  input  wire logic        wdtTimeout,
  input  wire logic        secOscStarted,
  input  wire logic        clockLoss,
  output logic             primaryOscEnable,
  output logic             secondaryOscRun,
  output logic             slowInternalRcRun,
  output logic             fastInternalOscEnable,
  output logic [1:0]       activeClockSource,
  output logic             wdtCounterClear
);
  import iws_pkg::*;
  // ------------------------------------------------------------
  // State registers
  // ------------------------------------------------------------
  iws_dev_t q;
  iws_dev_t d;
  localparam iws_cnt_t CPU_READY_DELAY_LAST   = iws_cnt_t'(CPU_READY_DELAY_CYC - 1);
  localparam iws_cnt_t TIOBST_LAST = iws_cnt_t'(TIOBST_CYC - 1);
  localparam iws_cnt_t OST_LAST    = iws_cnt_t'(OST_CYC - 1);
  // Decodes a clock source select into the internal block choice
  function automatic logic isInternal(input logic [1:0] css);
    isInternal = css[`IWS_CSS_HIGH_BIT];
  endfunction : isInternal
  logic wakeInt;
  logic wakeAny;
  logic fastWanted;
  logic internalActive;
  // Wake sources: enabled flags and the watchdog timeout count, other events never resume
  assign wakeInt = |(link.intFlags & link.intEnables);
  assign wakeAny = wakeInt | wdtTimeout;
  assign fastWanted = (link.internalFreqSelect != '0) | link.internalSourceSelect;
  assign internalActive = isInternal(q.clkSrc);

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.vectorBranch = 1'b0;
    d.wdtReset     = 1'b0;
    d.wdtClear     = 1'b0;
    // Synchronisers: stage 0 is read only by stage 1
    d.secSync  = {q.secSync[0], secOscStarted};
    d.lossSync = {q.lossSync[0], clockLoss};
    d.freqPrev = link.internalFreqSelect;

    // Primary start-up timer runs whenever the primary is powered
    if (!q.primaryOscEn)
    begin
      d.ostCnt       = '0;
      d.primaryReady = 1'b0;
    end
    else if (q.ostCnt != OST_LAST)
    begin
      d.ostCnt = q.ostCnt + 1'b1;
    end
    else if (!q.primaryReady)
    begin
      d.primaryReady = 1'b1;
    end

    // Fast internal output and its settle counter
    d.fastOscEn = fastWanted;
    if (!fastWanted)
    begin
      d.iofsCnt   = '0;
      d.intStable = 1'b0;
    end
    else if (q.intStable)
    begin
      d.intStable = 1'b1;
    end
    else if (q.iofsCnt != TIOBST_LAST)
    begin
      d.iofsCnt = q.iofsCnt + 1'b1;
    end
    else
    begin
      d.intStable = 1'b1;
    end
    // Clear instruction, retuning while on the internal clock, or losing the clock with fail-safe on restarts the watchdog
    if ((internalActive && (link.internalFreqSelect != q.freqPrev)) ||
        (q.lossSync[1] && link.failSafeEnable) || link.wdtClearExec)
    begin
      d.wdtClear = 1'b1;
    end
    // Slow RC for the watchdog and fail-safe monitor, secondary on its enable
    d.slowRcRun = link.wdtEnable | link.failSafeEnable | (internalActive & ~fastWanted);
    d.secOscRun = link.secOscEnable;

    unique case (q.state)
      ST_STARTUP:
      begin
        d.cpuClkEn    = 1'b0;
        d.periphClkEn = 1'b0;
        if (link.twoSpeedEnable || link.failSafeEnable)
        begin
          // Run early from the internal block
          d.state       = ST_RUN;
          d.clkSrc      = 2'h2;
          d.cpuClkEn    = 1'b1;
          d.periphClkEn = 1'b1;
        end
        else if (q.primaryReady)
        begin
          d.state       = ST_RUN;
          d.clkSrc      = `IWS_CSS_PRIMARY;
          d.cpuClkEn    = 1'b1;
          d.periphClkEn = 1'b1;
          d.intStable   = PRIMARY_IS_INTERNAL;
        end
      end

      ST_RUN:
      begin
        // Hand over to the primary once it is ready and the select bits name it
        if (q.clkSrc == 2'h2 && q.primaryReady && link.clockSourceSelect == `IWS_CSS_PRIMARY)
        begin
          d.clkSrc = `IWS_CSS_PRIMARY;
        end
        if (wdtTimeout)
        begin
          d.wdtReset = 1'b1;
        end
        else if (link.sleepExec)
        begin
          d.wdtClear = 1'b1;
          if (!link.idleSelect)
          begin
            // Full sleep stops the CPU, peripheral clocks and primary, and drops every ready flag
            d.state        = ST_SLEEP;
            d.cpuClkEn     = 1'b0;
            d.periphClkEn  = 1'b0;
            d.primaryOscEn = 1'b0;
            d.primaryReady = 1'b0;
            d.ostCnt       = '0;
            d.secRunFlag   = 1'b0;
            d.intStable    = 1'b0;
            d.iofsCnt      = '0;
          end
          else if (isInternal(link.clockSourceSelect))
          begin
            d.state        = ST_IDLE;
            d.clkSrc       = 2'h2;
            d.cpuClkEn     = 1'b0;
            d.primaryOscEn = 1'b0;
            d.primaryReady = 1'b0;
            d.ostCnt       = '0;
            d.secRunFlag   = 1'b0;
          end
          else if (link.clockSourceSelect == `IWS_CSS_SECONDARY)
          begin
            // Disabled secondary: the sleep is dropped, CPU keeps running
            if (link.secOscEnable)
            begin
              d.state        = ST_IDLE;
              d.clkSrc       = `IWS_CSS_SECONDARY;
              d.cpuClkEn     = 1'b0;
              d.periphClkEn  = q.secSync[1];
              d.primaryOscEn = 1'b0;
              d.primaryReady = 1'b0;
              d.ostCnt       = '0;
              d.secRunFlag   = 1'b1;
            end
          end
          else
          begin
            // Primary stays up, its ready flag is untouched
            d.state    = ST_IDLE;
            d.clkSrc   = `IWS_CSS_PRIMARY;
            d.cpuClkEn = 1'b0;
          end
        end
      end

      ST_IDLE:
      begin
        d.cpuClkEn = 1'b0;
        // Secondary idle holds peripheral clocks until the crystal runs
        d.periphClkEn = (q.clkSrc != `IWS_CSS_SECONDARY) | q.secSync[1];
        if (wakeAny)
        begin
          d.state     = ST_WAKE;
          d.tcsdCnt   = '0;
          d.wakeByInt = wakeInt;
        end
      end

      ST_SLEEP:
      begin
        d.cpuClkEn    = 1'b0;
        d.periphClkEn = 1'b0;
        if (wakeAny)
        begin
          // Wake into the source that the select bits name now
          d.state     = ST_WAKE;
          d.tcsdCnt   = '0;
          d.wakeByInt = wakeInt;
          d.clkSrc    = isInternal(link.clockSourceSelect) ? 2'h2 : link.clockSourceSelect;
          d.primaryOscEn = (link.clockSourceSelect == `IWS_CSS_PRIMARY);
          d.secRunFlag   = (link.clockSourceSelect == `IWS_CSS_SECONDARY);
        end
      end

      ST_WAKE:
      begin
        // Ready delay counts every cycle; a sleep exit to primary also
        // waits for the start-up timer unless early internal run is on
        if (q.tcsdCnt != CPU_READY_DELAY_LAST)
        begin
          d.tcsdCnt = q.tcsdCnt + 1'b1;
        end
        else if (q.clkSrc != `IWS_CSS_PRIMARY || q.primaryReady ||
                 link.twoSpeedEnable || link.failSafeEnable)
        begin
          // Resume in the run mode matching the idle source
          d.state        = ST_RUN;
          d.cpuClkEn     = 1'b1;
          d.periphClkEn  = 1'b1;
          d.vectorBranch = q.wakeByInt & link.globalIntEnable;
        end
      end

      default:
      begin
        d.state = ST_STARTUP;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Register update
  // ------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      q              <= '0;
      q.state        <= ST_STARTUP;
      q.primaryOscEn <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end
  // Select bits are only read here, so a wake never alters them
  assign link.cpuClkEn                = q.cpuClkEn;
  assign link.periphClkEn             = q.periphClkEn;
  assign link.primaryClockReadyFlag   = q.primaryReady;
  assign link.secondaryOscRunningFlag = q.secRunFlag;
  assign link.internalOscStableFlag   = q.intStable;
  assign link.intVectorBranch         = q.vectorBranch;
  assign link.wdtResetPulse           = q.wdtReset;
  assign primaryOscEnable             = q.primaryOscEn;
  assign secondaryOscRun              = q.secOscRun;
  assign slowInternalRcRun            = q.slowRcRun;
  assign fastInternalOscEnable        = q.fastOscEn;
  assign activeClockSource            = q.clkSrc;
  assign wdtCounterClear              = q.wdtClear;
endmodule : iws_device

// ---- iws_firmware.sv ----
`timescale 1ns/10ps
module iws_firmware #(
  parameter int NUM_IRQ = `IWS_NUM_IRQ
) (
  input  wire logic                   clock,
  input  wire logic                   rst_b,
  iws_if.fw                           link,
  input  wire logic                   fwSleep,
  input  wire logic                   fwWdtClear,
  input  wire logic                   fwIdleSelect,
  input  wire logic [1:0]             fwClockSourceSelect,
  input  wire logic                   fwSecOscEnable,
  input  wire logic [`IWS_FREQ_W-1:0] fwFreqSelect,
  input  wire logic                   fwIntSource,
  input  wire logic                   fwGlobalIntEnable,
  input  wire logic                   fwWdtEnable,
  input  wire logic                   fwFailSafeEnable,
  input  wire logic                   fwTwoSpeedEnable,
  input  wire logic [NUM_IRQ-1:0]     irqIn,
  input  wire logic [NUM_IRQ-1:0]     irqEnable,
  input  wire logic [NUM_IRQ-1:0]     irqClear,
  output logic                        cpuRunning,
  output logic                        vectorTaken,
  output logic                        wdtResetSeen
);
  import iws_pkg::*;

  // ------------------------------------------------------------
  // State registers
  // ------------------------------------------------------------
  typedef struct packed {
    logic                   sleepReq;
    logic                   wdtClrReq;
    logic                   idleSel;
    logic [1:0]             css;
    logic                   secEn;
    logic [`IWS_FREQ_W-1:0] freq;
    logic                   internal_source_select;
    logic                   gie;
    logic [NUM_IRQ-1:0]     flags;
    logic [NUM_IRQ-1:0]     enables;
    logic                   wdtEn;
    logic                   fsEn;
    logic                   tsEn;
    logic                   cpuRun;
    logic                   vector;
    logic                   wdtRst;
  } iws_fw_t;

  iws_fw_t q;
  iws_fw_t d;

  // Next state; instructions only issue while the CPU is clocked
  always_comb
  begin
    d = q;
    d.sleepReq  = fwSleep & link.cpuClkEn;
    d.wdtClrReq = fwWdtClear & link.cpuClkEn;
    d.idleSel   = fwIdleSelect;
    // Low select bit is cleared whenever the high bit is set
    d.css       = fwClockSourceSelect[`IWS_CSS_HIGH_BIT] ? 2'h2 : fwClockSourceSelect;
    d.secEn     = fwSecOscEnable;
    d.freq      = fwFreqSelect;
    d.internal_source_select    = fwIntSource;
    d.gie       = fwGlobalIntEnable;
    d.enables   = irqEnable;
    // Sticky interrupt flags: a new event wins over a clear
    d.flags     = (q.flags & ~irqClear) | irqIn;
    d.wdtEn     = fwWdtEnable;
    d.fsEn      = fwFailSafeEnable;
    d.tsEn      = fwTwoSpeedEnable;
    d.cpuRun    = link.cpuClkEn;
    d.vector    = link.intVectorBranch;
    d.wdtRst    = link.wdtResetPulse;
  end

  // Register update
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // Interface and user outputs straight from the registers
  assign link.sleepExec            = q.sleepReq;
  assign link.wdtClearExec         = q.wdtClrReq;
  assign link.idleSelect           = q.idleSel;
  assign link.clockSourceSelect    = q.css;
  assign link.secOscEnable         = q.secEn;
  assign link.internalFreqSelect   = q.freq;
  assign link.internalSourceSelect = q.internal_source_select;
  assign link.globalIntEnable      = q.gie;
  assign link.intFlags             = q.flags;
  assign link.intEnables           = q.enables;
  assign link.wdtEnable            = q.wdtEn;
  assign link.failSafeEnable       = q.fsEn;
  assign link.twoSpeedEnable       = q.tsEn;
  assign cpuRunning                = q.cpuRun;
  assign vectorTaken               = q.vector;
  assign wdtResetSeen              = q.wdtRst;
endmodule : iws_firmware

// ---- iws_if.sv ----
`timescale 1ns/10ps
interface iws_if #(parameter int NUM_IRQ = `IWS_NUM_IRQ);
  // Firmware to sequencer
  logic                   sleepExec;
  logic                   wdtClearExec;
  logic                   idleSelect;
  logic [1:0]             clockSourceSelect;
  logic                   secOscEnable;
  logic [`IWS_FREQ_W-1:0] internalFreqSelect;
  logic                   internalSourceSelect;
  logic                   globalIntEnable;
  logic [NUM_IRQ-1:0]     intFlags;
  logic [NUM_IRQ-1:0]     intEnables;
  logic                   wdtEnable;
  logic                   failSafeEnable;
  logic                   twoSpeedEnable;
  // Sequencer to firmware
  logic                   cpuClkEn;
  logic                   periphClkEn;
  logic                   primaryClockReadyFlag;
  logic                   secondaryOscRunningFlag;
  logic                   internalOscStableFlag;
  logic                   intVectorBranch;
  logic                   wdtResetPulse;

  modport dev (
    input  sleepExec, wdtClearExec, idleSelect, clockSourceSelect, secOscEnable,
    input  internalFreqSelect, internalSourceSelect, globalIntEnable, intFlags, intEnables,
    input  wdtEnable, failSafeEnable, twoSpeedEnable,
    output cpuClkEn, periphClkEn, primaryClockReadyFlag, secondaryOscRunningFlag,
    output internalOscStableFlag, intVectorBranch, wdtResetPulse
  );
  modport fw (
    output sleepExec, wdtClearExec, idleSelect, clockSourceSelect, secOscEnable,
    output internalFreqSelect, internalSourceSelect, globalIntEnable, intFlags, intEnables,
    output wdtEnable, failSafeEnable, twoSpeedEnable,
    input  cpuClkEn, periphClkEn, primaryClockReadyFlag, secondaryOscRunningFlag,
    input  internalOscStableFlag, intVectorBranch, wdtResetPulse
  );
endinterface : iws_if

// ---- iws_pkg.sv ----
`include "iws_consts.svh"
package iws_pkg;
  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_STARTUP = 5'h01,
    ST_RUN     = 5'h02,
    ST_IDLE    = 5'h04,
    ST_SLEEP   = 5'h08,
    ST_WAKE    = 5'h10
  } iws_state_t;

  typedef logic [`IWS_CNT_W-1:0] iws_cnt_t;

  // Whole device state
  typedef struct packed {
    iws_state_t            state;
    logic [1:0]            clkSrc;
    iws_cnt_t              tcsdCnt;
    iws_cnt_t              ostCnt;
    iws_cnt_t              iofsCnt;
    logic [`IWS_FREQ_W-1:0] freqPrev;
    logic                  wakeByInt;
    logic                  primaryOscEn;
    logic                  primaryReady;
    logic                  secRunFlag;
    logic                  intStable;
    logic                  fastOscEn;
    logic                  slowRcRun;
    logic                  secOscRun;
    logic                  cpuClkEn;
    logic                  periphClkEn;
    logic                  vectorBranch;
    logic                  wdtReset;
    logic                  wdtClear;
    logic [1:0]            secSync;
    logic [1:0]            lossSync;
  } iws_dev_t;
endpackage : iws_pkg
